// *** rtl/lfd_cfg.svh ***
// Opcodes, field positions, reset values and timing counts of the coil driver command block.
`ifndef LFD_CFG_SVH
`define LFD_CFG_SVH
`define LFD_OP_SEL_DRIVER     3'h1
`define LFD_OP_SEL_CURRENT    3'h5
`define LFD_OP_CARRIER        3'h4
`define LFD_OP_LF_DATA        4'h0
`define LFD_RST_GROUP         1'h0
`define LFD_RST_INDEX         2'h1
`define LFD_RST_STEP          5'h00
`define LFD_STEP_MAX          5'h13
`define LFD_LF_PER_BIT_NORM   6'h20
`define LFD_LF_PER_BIT_FAST   6'h16
`define LFD_CARRIER_ENDLESS   5'h00
`define LFD_FLT_GROUP_BIT     7
`define LFD_FLT_THERMAL_BIT   4
`endif

// *** rtl/lfd_pkg.sv ***
// Types shared by the coil driver command block.
package lfd_pkg;
   typedef struct packed {
      logic       speed;
      logic       diag;
      logic       group;
      logic [1:0] index;
   } lfd_setup_t;

   typedef struct packed {
      logic       no_return;
      logic       shunt_ov;
      logic       hs_oc;
      logic       ls_oc;
   } lfd_fault_t;

   typedef enum logic [2:0] {
      LFD_IDLE    = 3'h0,
      LFD_FETCH   = 3'h1,
      LFD_DATA    = 3'h3,
      LFD_CARRIER = 3'h2,
      LFD_WAIT    = 3'h6
   } lfd_state_t;
endpackage

// *** rtl/lfd_cmd.sv ***
// Driver command interpreter with fault register and interrupt request.
`timescale 1ns/1ps
`include "lfd_cfg.svh"

// Contract
// - Driver commands are taken from the buffer and executed strictly in order.
// - Channel select is 001, speed, diagnosis, group and two-bit index.
// - Bit time is 32 LF periods normally, 22 at high speed.
// - Group 0 picks drivers 1 to 3, group 1 drivers 4 to 6.
// - Diagnosis bit set enters diagnosis and blocks LF; cleared returns to normal.
// - Reset gives channel 1, no diagnosis, normal speed, step zero.
// - Current select is 101 plus step; only steps 0 to 19 accepted.
// - In diagnosis, step bits 0 and 1 drive the line test switches.
// - Data header is 0000 plus nibble count minus one.
// - Header word is held in the buffer with its data words.
// - Carrier is 100 plus duration counted in LF bit times.
// - Duration zero gives an endless carrier until halted.
// - Carrier uses the last selected step, or the reset step.
// - Any stored fault disables all coil power stages.
// - Storing a fault raises the interrupt until status is read.
// - Fault register clears only by fault reset or global reset.
// - Fault register holds group, index, thermal bit and four fault types.
// - Type bits: no return, shunt overvoltage, high-side and low-side overcurrent.
// - Without operability every driver command except channel select is refused.
module lfd_cmd
   import lfd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] cmd_word,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       lf_clk_pin,
   input  wire logic       halt_pulse,
   input  wire logic       fault_reset_pulse,
   input  wire logic       status_read_pulse,
   input  wire logic       supplies_ok,
   input  wire lfd_fault_t fault_event,
   input  wire logic       thermal_event,
   output lfd_setup_t      setup,
   output logic [4:0]      current_step,
   output logic [7:0]      driver_fault_log,
   output logic            operability_flag,
   output logic            irq,
   output logic            stages_enable,
   output logic            coil_positive_line,
   output logic            coil_negative_line,
   output logic            lf_active,
   output logic            lf_bit_tick,
   output logic            lf_out
);
   // Pin sampler: the first stage feeds only the second.
   logic       lf_s1_reg, lf_s2_reg, lf_s3_reg;
   logic       lf_edge;

   lfd_setup_t setup_reg, setup_next;
   logic [4:0] step_reg, step_next;
   logic [7:0] flt_reg, flt_next;
   logic       irq_reg, irq_next;
   lfd_state_t st_reg, st_next;
   logic [5:0] per_reg, per_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [3:0] nib_reg, nib_next;
   logic [7:0] sh_reg, sh_next;
   logic       tick_reg, tick_next;
   logic       out_reg, out_next;
   logic       endless_reg, endless_next;
   logic       bit_end;
   logic [5:0] bit_len;
   logic       cmd_take;

   function automatic logic fault_any(input logic [7:0] f);
      fault_any = |f[`LFD_FLT_THERMAL_BIT:0];
   endfunction

   // Opcode decoders: select and current for the setup group, carrier and data for the transmit engine.
   function automatic logic is_select(input logic [7:0] w);
      is_select = (w[7:5] == `LFD_OP_SEL_DRIVER);
   endfunction

   function automatic logic is_current(input logic [7:0] w);
      is_current = (w[7:5] == `LFD_OP_SEL_CURRENT);
   endfunction

   function automatic logic is_carrier(input logic [7:0] w);
      is_carrier = (w[7:5] == `LFD_OP_CARRIER);
   endfunction

   function automatic logic is_lf_data(input logic [7:0] w);
      is_lf_data = (w[7:4] == `LFD_OP_LF_DATA);
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lf_s1_reg <= 1'b0;
         lf_s2_reg <= 1'b0;
         lf_s3_reg <= 1'b0;
      end else begin
         lf_s1_reg <= lf_clk_pin;
         lf_s2_reg <= lf_s1_reg;
         lf_s3_reg <= lf_s2_reg;
      end
   end
   assign lf_edge = lf_s2_reg & ~lf_s3_reg;

   // Any stored thermal or type bit drops operability; the channel bits alone hold none.
   assign operability_flag = ~fault_any(flt_reg) & supplies_ok;
   assign bit_len = setup_reg.speed ? `LFD_LF_PER_BIT_FAST : `LFD_LF_PER_BIT_NORM;
   assign bit_end = lf_edge && (per_reg == bit_len - 6'h01);
   // Commands are taken only in idle and data words only in fetch, so all runs in order.
   assign cmd_ready = (st_reg == LFD_IDLE) || (st_reg == LFD_FETCH);
   // A word taken in idle is a command; in fetch it is always data.
   assign cmd_take = cmd_valid && (st_reg == LFD_IDLE);

   // Setup and step; a select is honoured without operability so that diagnosis can be left.
   always_comb begin
      setup_next = setup_reg;
      step_next  = step_reg;
      if (cmd_take && is_select(cmd_word)) begin
         setup_next.speed = cmd_word[4];
         setup_next.diag  = cmd_word[3];
         setup_next.group = cmd_word[2];
         setup_next.index = cmd_word[1:0];
      end else if (cmd_take && operability_flag && is_current(cmd_word)) begin
         // Out-of-range steps are dropped, so the last valid step stays in force.
         if (cmd_word[4:0] <= `LFD_STEP_MAX) begin
            step_next = cmd_word[4:0];
         end
      end
   end

   // Transmit engine: one LF period counter serves carrier and Manchester data.
   always_comb begin
      st_next      = st_reg;
      per_next     = per_reg;
      cnt_next     = cnt_reg;
      nib_next     = nib_reg;
      sh_next      = sh_reg;
      tick_next    = 1'b0;
      out_next     = out_reg;
      endless_next = endless_reg;
      // The period counter runs while a bit is in flight; a fetch restarts it.
      if (st_reg == LFD_DATA || st_reg == LFD_WAIT || st_reg == LFD_CARRIER) begin
         if (lf_edge) begin
            per_next = bit_end ? 6'h00 : per_reg + 6'h01;
         end
      end
      case (st_reg)
         LFD_IDLE: begin
            out_next = 1'b0;
            // Refused data and carrier words are still consumed from the buffer.
            if (cmd_valid && operability_flag && !setup_reg.diag) begin
               if (is_carrier(cmd_word)) begin
                  cnt_next     = cmd_word[4:0];
                  endless_next = (cmd_word[4:0] == `LFD_CARRIER_ENDLESS);
                  per_next     = 6'h00;
                  out_next     = 1'b1;
                  st_next      = LFD_CARRIER;
               end else if (is_lf_data(cmd_word)) begin
                  nib_next = cmd_word[3:0];
                  st_next  = LFD_FETCH;
               end
            end
         end
         LFD_FETCH: begin
            // The first bit of each word is timed from its fetch.
            if (cmd_valid) begin
               sh_next  = cmd_word;
               cnt_next = 5'h00;
               per_next = 6'h00;
               out_next = cmd_word[0];
               st_next  = LFD_DATA;
            end
         end
         LFD_DATA: begin
            // Manchester: first half carries the bit, second half its inverse.
            if (lf_edge && per_reg == (bit_len >> 1) - 6'h01) begin
               out_next = ~sh_reg[0];
            end
            // Each finished LF bit pulses the bit counter output once.
            if (bit_end) begin
               tick_next = 1'b1;
               sh_next   = {1'b0, sh_reg[7:1]};
               cnt_next  = cnt_reg + 5'h01;
               out_next  = sh_reg[1];
               if (cnt_reg[1:0] == 2'h3) begin
                  // The last nibble ends the run; an odd count never sends its dummy half.
                  if (nib_reg == 4'h0) begin
                     out_next = 1'b0;
                     st_next  = LFD_IDLE;
                  end else begin
                     nib_next = nib_reg - 4'h1;
                     if (cnt_reg[2]) begin
                        st_next = LFD_WAIT;
                     end
                  end
               end
            end
         end
         LFD_WAIT: begin
            // One spare cycle lets the host present the next data word.
            st_next = LFD_FETCH;
         end
         LFD_CARRIER: begin
            // An endless carrier is only ended by halt or a stored fault.
            if (bit_end && !endless_reg) begin
               if (cnt_reg == 5'h01) begin
                  out_next = 1'b0;
                  st_next  = LFD_IDLE;
               end
               cnt_next = cnt_reg - 5'h01;
            end
         end
         default: st_next = LFD_IDLE;
      endcase
      // Halt and a stored fault stop the engine at once, not at the end of an LF period.
      if ((halt_pulse || fault_any(flt_reg)) && st_reg != LFD_IDLE) begin
         st_next  = LFD_IDLE;
         out_next = 1'b0;
      end
   end

   always_comb begin
      flt_next = flt_reg;
      irq_next = irq_reg;
      if (fault_reset_pulse) begin
         flt_next = 8'h00;
      end
      // A status read in the cycle of a new fault leaves the request raised.
      if (status_read_pulse) begin
         irq_next = 1'b0;
      end
      // A fault that arrives with the clear still lands.
      if (|fault_event || thermal_event) begin
         flt_next = {setup_reg.group, setup_reg.index,
                     flt_next[`LFD_FLT_THERMAL_BIT] | thermal_event,
                     flt_next[3:0] | fault_event};
         irq_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_reg <= '{speed: 1'b0, diag: 1'b0, group: `LFD_RST_GROUP,
                        index: `LFD_RST_INDEX};
         step_reg  <= `LFD_RST_STEP;
      end else begin
         setup_reg <= setup_next;
         step_reg  <= step_next;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flt_reg <= 8'h00;
         irq_reg <= 1'b0;
      end else begin
         flt_reg <= flt_next;
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg      <= LFD_IDLE;
         per_reg     <= 6'h00;
         cnt_reg     <= 5'h00;
         nib_reg     <= 4'h0;
         sh_reg      <= 8'h00;
         tick_reg    <= 1'b0;
         out_reg     <= 1'b0;
         endless_reg <= 1'b0;
      end else begin
         st_reg      <= st_next;
         per_reg     <= per_next;
         cnt_reg     <= cnt_next;
         nib_reg     <= nib_next;
         sh_reg      <= sh_next;
         tick_reg    <= tick_next;
         out_reg     <= out_next;
         endless_reg <= endless_next;
      end
   end

   assign setup              = setup_reg;
   assign current_step       = step_reg;
   assign driver_fault_log   = flt_reg;
   assign irq                = irq_reg;
   // Diagnosis keeps the stages off and hands the line switches to the two low step bits.
   assign stages_enable      = ~fault_any(flt_reg) & ~setup_reg.diag;
   assign coil_positive_line = setup_reg.diag & step_reg[0];
   assign coil_negative_line = setup_reg.diag & step_reg[1];
   assign lf_active          = (st_reg != LFD_IDLE);
   assign lf_bit_tick        = tick_reg;
   // A stored fault forces the modulator low even before the engine has stopped.
   assign lf_out             = out_reg & ~fault_any(flt_reg);
endmodule

// *** verification/lfd_cmd_checker.sv ***
// Port assertions for the coil driver command block.
`timescale 1ns/1ps
module lfd_cmd_checker
   import lfd_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [7:0] cmd_word,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       fault_reset_pulse,
   input wire logic       status_read_pulse,
   input wire lfd_fault_t fault_event,
   input wire lfd_setup_t setup,
   input wire logic [4:0] current_step,
   input wire logic [7:0] driver_fault_log,
   input wire logic       operability_flag,
   input wire logic       irq,
   input wire logic       stages_enable,
   input wire logic       lf_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic tk, sel, cur;
   assign tk = cmd_valid && cmd_ready && !lf_active;
   assign sel = tk && cmd_word[7:5] == 3'h1;
   assign cur = tk && cmd_word[7:5] == 3'h5;
   AST_SEL: assert property (sel |=> setup == $past(cmd_word[4:0]))
      else $error("select lost");
   AST_STEP: assert property (cur && cmd_word[4:0] < 5'h14 && operability_flag
      |=> current_step == $past(cmd_word[4:0])) else $error("step lost");
   AST_STEP_CAP: assert property (cur && cmd_word[4:0] > 5'h13 |=> $stable(current_step))
      else $error("bad step taken");
   AST_REFUSE: assert property (tk && !sel && !operability_flag |=> $stable(current_step))
      else $error("taken while inoperable");
   AST_STAGES: assert property (driver_fault_log[4:0] != 5'h00 |-> !stages_enable)
      else $error("stages on");
   AST_IRQ_SET: assert property (fault_event != 4'h0 && !status_read_pulse |=> irq)
      else $error("no irq");
   AST_IRQ_HOLD: assert property (irq && !status_read_pulse |=> irq)
      else $error("irq dropped");
   AST_LOG: assert property (driver_fault_log[4:0] != 5'h00 && !fault_reset_pulse
      |=> driver_fault_log[4:0] != 5'h00) else $error("log lost");
endmodule
bind lfd_cmd lfd_cmd_checker i_lfd_cmd_checker (.*);

// *** verification/lfd_host.sv ***
// Host model that offers buffered command words to the coil driver block.
`timescale 1ns/1ps
module lfd_host (
   input  wire logic  clk,
   input  wire logic  nrst,
   input  wire logic  cmd_ready,
   input  wire logic  stall,
   output logic [7:0] cmd_word = 8'h00,
   output logic       cmd_valid = 1'b0
);
   logic [7:0] q[$];
   always @(posedge clk) begin
      if (cmd_valid && cmd_ready) void'(q.pop_front());
   end
   // A stall only delays a new word; an offered word is held until taken.
   // Idle data keeps toggling so a stale value is never read as a word.
   always @(negedge clk) begin
      cmd_valid <= nrst && q.size() > 0 && (cmd_valid || !stall);
      cmd_word <= q.size() > 0 ? q[0] : ~cmd_word;
   end
endmodule

// *** verification/test_lfd_cmd.sv ***
// Self-checking bench for the coil driver command block.
`timescale 1ns/1ps
module test_lfd_cmd
   import lfd_pkg::*;
;
   logic        clk = 1'b0, nrst = 1'b0, lf_clk_pin = 1'b0, stall = 1'b0, halt_pulse = 1'b0;
   logic        fault_reset_pulse = 1'b0, status_read_pulse = 1'b0, supplies_ok = 1'b1;
   logic        thermal_event = 1'b0, cmd_valid, cmd_ready, irq, stages_enable, lf_out;
   logic        operability_flag, coil_positive_line, coil_negative_line, lf_active, lf_bit_tick;
   logic [7:0]  cmd_word, driver_fault_log, w;
   logic [4:0]  current_step;
   logic [19:0] e, exp_q[$];
   logic [15:0] obs[8];
   lfd_fault_t  fault_event = 4'h0;
   lfd_setup_t  setup;
   int          failures = 0, n_compared = 0, ticks = 0, act = 0, cyc = 0, last = 0, gap = 0;
   lfd_cmd i_lfd_cmd (.*);
   lfd_host i_lfd_host (.clk, .nrst, .cmd_ready, .stall, .cmd_word, .cmd_valid);
   always #5 clk = ~clk;
   // A fixed offset to clk keeps the bit spacing an exact multiple of eight cycles.
   always #40 lf_clk_pin = ~lf_clk_pin;
   always @(negedge clk) stall <= ($urandom_range(3) == 0);
   assign obs = '{16'(setup), 16'(current_step), 16'(driver_fault_log),
      16'({stages_enable, irq, operability_flag}), 16'(ticks), 16'(gap),
      16'({lf_out, coil_positive_line, coil_negative_line}), 16'((act + 16) / 176)};
   always @(posedge clk) begin
      cyc <= cyc + 1;
      act <= act + int'(lf_active);
      if (lf_bit_tick) begin
         gap <= cyc - last;
         last <= cyc;
         ticks <= ticks + 1;
      end
   end
   always begin
      wait (exp_q.size() != 0);
      e = exp_q.pop_front();
      n_compared++;
      if (obs[e[18:16]] !== e[15:0]) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, obs[e[18:16]], e[15:0]);
      end
   end
   task chk(input logic [3:0] s, input logic [15:0] v);
      exp_q.push_back({s, v});
   endtask
   task run(input logic [7:0] x);
      i_lfd_host.q.push_back(x);
      do @(negedge clk);
      while (i_lfd_host.q.size() > 0 || cmd_valid || lf_active);
      repeat (2) @(negedge clk);
   endtask
   task pls(input logic [7:0] k);
      {halt_pulse, fault_reset_pulse, status_read_pulse, thermal_event, fault_event} = k;
      @(negedge clk);
      {halt_pulse, fault_reset_pulse, status_read_pulse, thermal_event, fault_event} = 8'h00;
      @(negedge clk);
   endtask
   task end_of_test();
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // The whole sequence needs about a fifth of this span.
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
   initial begin
      void'($urandom(73489));
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk(0, 16'h01);
      chk(1, 16'h00);
      chk(3, 16'h5);
      for (int i = 0; i < 8; i++) begin
         w = 8'(i) | 8'($urandom_range(1) << 4);
         run(8'h20 | w);
         chk(0, 16'(w));
      end
      i_lfd_host.q.push_back(8'hb3);
      run(8'hb4);
      chk(1, 16'h13);
      for (int s = 0; s < 2; s++) begin
         i_lfd_host.q.push_back(8'h21 | 8'(s << 4));
         i_lfd_host.q.push_back(8'(s));
         ticks = 0;
         run(8'h5a);
         chk(4, 16'(4 * s + 4));
         chk(5, 16'(s ? 176 : 256));
      end
      act = 0;
      run(8'h83);
      chk(7, 16'h3);
      chk(4, 16'h8);
      run(8'ha0);
      chk(1, 16'h00);
      act = 0;
      i_lfd_host.q.push_back(8'h80);
      repeat (700) @(negedge clk);
      chk(6, 16'h4);
      pls(8'h80);
      chk(7, 16'h4);
      act = 0;
      i_lfd_host.q.push_back(8'h2a);
      i_lfd_host.q.push_back(8'hb3);
      run(8'h81);
      chk(7, 16'h0);
      chk(6, 16'h3);
      run(8'h21);
      pls(8'h40);
      chk(0, 16'h01);
      for (int f = 0; f < 5; f++) begin
         w = f[0] ? 8'h25 : 8'h23;
         run(w);
         pls(8'h01 << f);
         chk(2, {8'h00, w[2:0], 5'(8'h01 << f)});
         chk(3, 16'h2);
         run(8'hb1);
         chk(1, 16'h13);
         pls(8'h20);
         chk(3, 16'h0);
         run(8'h21);
         pls(8'h40);
         chk(2, 16'h0);
      end
      end_of_test();
   end
endmodule
